// File: lpm_pkg.sv
package lpm_pkg;

    // ======================================================
    // register map
    localparam logic [7:0] ctrl_off      = 8'h00;
    localparam logic [7:0] monitor_off   = 8'h04;
    localparam logic [7:0] state_off     = 8'h08;
    localparam logic [7:0] irq_stat_off  = 8'h0c;
    localparam logic [7:0] irq_mask_off  = 8'h10;

    // ======================================================
    // control bit positions
    localparam int standby_sel_bit  = 0;
    localparam int clk_stop_en_bit  = 1;
    localparam int deep_sel_bit     = 2;
    localparam int bus_pin_oe_bit   = 3;
    localparam int deep_cut_lsb     = 4;
    localparam int tmr0_run_bit     = 6;
    localparam int tmr1_run_bit     = 7;
    localparam int shutoff_run_bit  = 8;
    localparam int periph_run_bit   = 9;
    localparam int ctrl_width       = 10;
    localparam logic [9:0] ctrl_rst = 10'h000;

    // monitor bit positions
    localparam int mon1_sel_bit     = 0;
    localparam int mon2_sel_bit     = 1;
    localparam int mon2_cmp_oe_bit  = 2;
    localparam int mon2_irq_en_bit  = 3;
    localparam int mon2_filt_off_bit = 4;
    localparam int det2_en_bit      = 5;
    localparam logic [5:0] monitor_rst = 6'h00;

    // interrupt status bits
    localparam int ev_wake_bit      = 0;
    localparam int ev_redirect_bit  = 1;
    localparam int ev_shutoff_bit   = 2;
    localparam logic [2:0] irq_rst  = 3'h0;
    localparam logic [1:0] deep_cut_all = 2'h3;

    typedef enum logic [2:0] {
        st_run, st_sleep, st_clk_stop, st_sw_stby, st_deep_stby, st_deep_exit
    } lpm_state_e;

    // clock and power gate of one controlled unit
    typedef struct packed {
        logic run;
        logic powered;
    } unit_ctl_s;

endpackage

// File: low_power_mode_states.sv
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_states
    import lpm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic        wait_exec,
    input  wire logic        nmi_pin,
    input  wire logic [15:0] external_pin_interrupts,
    input  wire logic [7:0]  periph_wake,
    input  wire logic        shutoff_cond,
    output unit_ctl_s        eight_bit_timer_unit0,
    output unit_ctl_s        eight_bit_timer_unit1,
    output unit_ctl_s        pin_shutoff_unit,
    output unit_ctl_s        periph_units,
    output logic             voltage_detector_run,
    output logic             por_low_power,
    output logic             bus_clk_keep,
    output logic             bus_pins_hold,
    output logic             bus_pins_hiz,
    output logic             module_reset_n,
    output logic             shutoff_irq,
    output logic [2:0]       mode_state,
    output logic             irq
);

    // ======================================================
    // assertion clock and reset
    default clocking lpm_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ======================================================
    // pin synchronisers
    logic [16:0] pin_meta_q;
    logic [16:0] pin_sync_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {nmi_pin, external_pin_interrupts};
            pin_sync_q <= pin_meta_q;
        end
    end

    // ======================================================
    // registers
    logic [ctrl_width-1:0] ctrl_q;
    logic [5:0]            mon_q;
    logic [2:0]            stat_q;
    logic [2:0]            stat_d;
    logic [2:0]            mask_q;
    logic [31:0]           prdata_q;
    lpm_state_e            state_q;
    lpm_state_e            state_d;

    // bus decode
    wire setup_ph = psel && !penable;
    wire wr_acc   = psel && penable && pwrite;
    wire hit_ctrl = paddr == ctrl_off;
    wire hit_mon  = paddr == monitor_off;
    wire hit_st   = paddr == state_off;
    wire hit_is   = paddr == irq_stat_off;
    wire hit_im   = paddr == irq_mask_off;
    wire hit_any  = hit_ctrl || hit_mon || hit_st || hit_is || hit_im;

    wire [31:0] rd_mux =
        hit_ctrl ? {{(32-ctrl_width){1'b0}}, ctrl_q} :
        hit_mon  ? {26'h0, mon_q} :
        hit_st   ? {29'h0, state_q} :
        hit_is   ? {29'h0, stat_q} :
        hit_im   ? {29'h0, mask_q} : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign prdata  = prdata_q;

    // control field views
    wire       in_run     = state_q == st_run;
    wire       want_stby  = ctrl_q[standby_sel_bit];
    wire       want_stop  = ctrl_q[clk_stop_en_bit];
    wire       want_deep  = ctrl_q[deep_sel_bit];
    wire [1:0] deep_cut_field = ctrl_q[deep_cut_lsb +: 2];
    wire       monitor1_mode_select = mon_q[mon1_sel_bit];
    wire       monitor2_mode_select = mon_q[mon2_sel_bit];
    wire       detector2_enable     = mon_q[det2_en_bit];
    wire       deep_block = monitor1_mode_select || monitor2_mode_select;

    // wake sources: pins after sync, peripherals same clock
    wire wake     = (|pin_sync_q) || (|periph_wake);
    wire enter    = in_run && wait_exec;
    wire redirect = enter && want_stby && want_deep && deep_block;

    // ======================================================
    // mode sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_run: begin
                if (enter) begin
                    if (!want_stby) begin
                        state_d = want_stop ? st_clk_stop : st_sleep;
                    end else if (want_deep && !deep_block) begin
                        state_d = st_deep_stby;
                    end else begin
                        state_d = st_sw_stby;
                    end
                end
            end
            st_sleep, st_clk_stop, st_sw_stby: begin
                if (wake) begin
                    state_d = st_run;
                end
            end
            st_deep_stby: begin
                if (wake) begin
                    state_d = st_deep_exit;
                end
            end
            default: begin
                state_d = st_run;
            end
        endcase
    end

    // ======================================================
    // interrupt status: set wins over write-one clear
    wire [2:0] ev_set = {shutoff_cond,
                         redirect,
                         wake && !in_run && state_q != st_deep_exit};
    wire [2:0] w1c    = (wr_acc && hit_is) ? pwdata[2:0] : 3'h0;

    always_comb begin
        stat_d = (stat_q & ~w1c) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= st_run;
            stat_q  <= irq_rst;
        end else begin
            state_q <= state_d;
            stat_q  <= stat_d;
        end
    end

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ctrl_rst;
            mon_q  <= monitor_rst;
            mask_q <= irq_rst;
        end else if (wr_acc) begin
            if (hit_ctrl) begin
                ctrl_q <= pwdata[ctrl_width-1:0];
            end else if (hit_mon) begin
                mon_q <= pwdata[5:0];
            end else if (hit_im) begin
                mask_q <= pwdata[2:0];
            end
        end
    end

    // read data captured in setup so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (setup_ph && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // ======================================================
    // unit clock and power gating per mode
    wire opt_mode = state_q == st_sleep || state_q == st_clk_stop;
    wire deep     = state_q == st_deep_stby;
    wire stby     = state_q == st_sw_stby || deep;
    wire clk_stop = state_q == st_clk_stop;

    // halted units keep power (retained); deep cuts it (undefined)
    assign eight_bit_timer_unit0.run =
        in_run || (opt_mode && ctrl_q[tmr0_run_bit]);
    assign eight_bit_timer_unit1.run =
        in_run || (opt_mode && ctrl_q[tmr1_run_bit]);
    assign pin_shutoff_unit.run =
        in_run || (opt_mode && ctrl_q[shutoff_run_bit]);
    assign periph_units.run =
        in_run || (state_q == st_sleep && ctrl_q[periph_run_bit]);
    assign eight_bit_timer_unit0.powered = !deep;
    assign eight_bit_timer_unit1.powered = !deep;
    assign pin_shutoff_unit.powered      = !deep;
    assign periph_units.powered          = !deep;

    // detector and power-on reset in deep standby
    wire cut_all = deep && deep_cut_field == deep_cut_all;
    assign voltage_detector_run = detector2_enable && !cut_all;
    assign por_low_power        = cut_all;

    // bus pins
    assign bus_clk_keep  = !stby;
    assign bus_pins_hold = stby && ctrl_q[bus_pin_oe_bit];
    assign bus_pins_hiz  = stby && !ctrl_q[bus_pin_oe_bit];

    // lost units reset on the way out of deep standby
    assign module_reset_n = state_q != st_deep_exit;

    // shutoff flag held back while the clocks are stopped
    assign shutoff_irq = stat_q[ev_shutoff_bit] && !clk_stop;

    assign mode_state = state_q;
    // shutoff bit kept off the irq line while clocks are stopped
    wire [2:0] irq_src = stat_q & mask_q & {!clk_stop, 2'b11};
    assign irq        = |irq_src;

    // ======================================================
    // assertions
    sequence s_enter_deep;
        in_run && wait_exec && want_stby && want_deep && !deep_block;
    endsequence

    sequence s_deep_wake;
        deep && wake;
    endsequence

    sequence s_exit_pulse;
        !module_reset_n ##1 module_reset_n && in_run;
    endsequence

    a_wait_entry: assert property (
        in_run && !wait_exec |=> state_q == st_run)
        else $error("mode left without wait");

    a_sleep_entry: assert property (
        enter && !want_stby && !want_stop |=> state_q == st_sleep)
        else $error("sleep not entered");

    a_stop_entry: assert property (
        enter && !want_stby && want_stop |=> clk_stop)
        else $error("clock stop not entered");

    a_stby_entry: assert property (
        enter && want_stby && !want_deep |=> state_q == st_sw_stby)
        else $error("software standby not entered");

    a_deep_entry: assert property (
        s_enter_deep |=> deep)
        else $error("deep standby not entered");

    a_redirect_stby: assert property (
        redirect |=> state_q == st_sw_stby && stat_q[ev_redirect_bit])
        else $error("blocked deep entry not redirected");

    a_wake_exit: assert property (
        (opt_mode || state_q == st_sw_stby) && wake |=> in_run)
        else $error("wake source did not end the mode");

    a_mode_held: assert property (
        !in_run && state_q != st_deep_exit && !wake |=> $stable(state_q))
        else $error("mode left without a wake source");

    a_wake_flag: assert property (
        wake && !in_run && state_q != st_deep_exit |=> stat_q[ev_wake_bit])
        else $error("wake event not flagged");

    a_timer_halt: assert property (
        stby |-> !eight_bit_timer_unit0.run && !eight_bit_timer_unit1.run
                 && !pin_shutoff_unit.run && !periph_units.run)
        else $error("unit running in standby");

    a_unit_power: assert property (
        $rose(deep) |-> !periph_units.powered && $past(periph_units.powered))
        else $error("power not cut in deep standby");

    a_deep_unpowered: assert property (
        deep |-> !eight_bit_timer_unit0.powered
                 && !eight_bit_timer_unit1.powered
                 && !pin_shutoff_unit.powered)
        else $error("unit powered in deep standby");

    a_retain_power: assert property (
        state_q == st_sw_stby |-> pin_shutoff_unit.powered
                                  && eight_bit_timer_unit1.powered)
        else $error("retained unit lost power");

    a_stop_retain: assert property (
        clk_stop |-> !periph_units.run && periph_units.powered)
        else $error("peripherals not retained in clock stop");

    a_deep_cut: assert property (
        deep && deep_cut_field == deep_cut_all |-> por_low_power
                                                  && !voltage_detector_run)
        else $error("deep cut not applied");

    a_no_cut: assert property (
        !cut_all |-> !por_low_power
                     && voltage_detector_run == detector2_enable)
        else $error("detector state wrong without deep cut");

    a_deep_reset: assert property (
        s_deep_wake |=> s_exit_pulse)
        else $error("deep exit reset missing");

    a_shutoff_hold: assert property (
        clk_stop && shutoff_cond |=> stat_q[ev_shutoff_bit]
                                     && (!clk_stop || !shutoff_irq))
        else $error("shutoff flag mishandled in clock stop");

    a_shutoff_no_wake: assert property (
        clk_stop && shutoff_cond && !wake |=> clk_stop)
        else $error("shutoff event woke clock stop");

    a_irq_held: assert property (
        clk_stop |-> irq == |(stat_q[1:0] & mask_q[1:0]))
        else $error("shutoff irq raised in clock stop");

    a_shutoff_set: assert property (
        shutoff_cond |=> stat_q[ev_shutoff_bit])
        else $error("shutoff event lost");

    a_bus_pins: assert property (
        stby |-> bus_pins_hold == ctrl_q[bus_pin_oe_bit]
                 && bus_pins_hiz != bus_pins_hold && !bus_clk_keep)
        else $error("bus pin state wrong in standby");

    a_run_pins: assert property (
        !stby |-> bus_clk_keep && !bus_pins_hold && !bus_pins_hiz)
        else $error("bus pins disturbed outside standby");

    a_clk_stop_bus: assert property (
        clk_stop |-> bus_clk_keep)
        else $error("bus clock dropped in clock stop");

    a_opt_run: assert property (
        opt_mode |-> eight_bit_timer_unit1.run == ctrl_q[tmr1_run_bit])
        else $error("optional run bit ignored");

    a_opt_timer0: assert property (
        opt_mode |-> eight_bit_timer_unit0.run == ctrl_q[tmr0_run_bit])
        else $error("timer 0 run bit ignored");

    a_opt_shutoff: assert property (
        opt_mode |-> pin_shutoff_unit.run == ctrl_q[shutoff_run_bit])
        else $error("shutoff run bit ignored");

endmodule

`default_nettype wire

// File: low_power_mode_states_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_states_tb_top;
    import lpm_pkg::*;

    // ==========================================================
    // stimulus and observed signals
    logic        pclk, presetn, psel, penable, pwrite, wait_exec;
    logic        nmi_pin, shutoff_cond;
    logic [7:0]  paddr, periph_wake;
    logic [31:0] pwdata, prdata, rd_q;
    logic [15:0] external_pin_interrupts;
    logic        pready, pslverr, bus_clk_keep, bus_pins_hold;
    logic        bus_pins_hiz, module_reset_n, shutoff_irq, irq, err_q;
    logic        voltage_detector_run, por_low_power;
    logic [2:0]  mode_state;
    unit_ctl_s   tmr0, tmr1, shut_u, peri_u;
    int          bad_count, num_checks, ctrl_m, mon_m, stat_m, mask_m, st;
    int          base[6] = '{'h000, 'h002, 'h001, 'h005, 'h005, 'h005};
    int          mons[6] = '{0, 0, 0, 0, 1, 2};

    low_power_mode_states dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .wait_exec(wait_exec),
        .nmi_pin(nmi_pin), .external_pin_interrupts(external_pin_interrupts),
        .periph_wake(periph_wake), .shutoff_cond(shutoff_cond),
        .eight_bit_timer_unit0(tmr0), .eight_bit_timer_unit1(tmr1),
        .pin_shutoff_unit(shut_u), .periph_units(peri_u),
        .voltage_detector_run(voltage_detector_run),
        .por_low_power(por_low_power), .bus_clk_keep(bus_clk_keep),
        .bus_pins_hold(bus_pins_hold), .bus_pins_hiz(bus_pins_hiz),
        .module_reset_n(module_reset_n), .shutoff_irq(shutoff_irq),
        .mode_state(mode_state), .irq(irq)
    );

    // ==========================================================
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end

    // ==========================================================
    // compare, bus and mode helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input int d);
        apb(1'b1, a, d);
        case (a)
            ctrl_off:     ctrl_m = d & 'h3ff;
            monitor_off:  mon_m = d & 'h3f;
            irq_stat_off: stat_m = stat_m & ~d;
            irq_mask_off: mask_m = d & 7;
            default:      ;
        endcase
    endtask

    task automatic rd(input logic [7:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask

    task automatic wait_state(input logic [2:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (mode_state !== exp && n < 20);
        chk(32'(mode_state), 32'(exp));
    endtask

    function automatic logic [12:0] exp_units(input int s);
        logic [9:0] c;
        logic       r0, sl, stb, dp, cut;
        c = ctrl_m[9:0];
        r0 = (s == 0);
        sl = (s == 1) || (s == 2);
        stb = (s == 3) || (s == 4);
        dp = (s == 4);
        cut = dp && (c[5:4] == deep_cut_all);
        return {r0 | (sl & c[tmr0_run_bit]), !dp,
                r0 | (sl & c[tmr1_run_bit]), !dp,
                r0 | (sl & c[shutoff_run_bit]), !dp,
                r0 | ((s == 1) & c[periph_run_bit]), !dp,
                mon_m[det2_en_bit] & !cut, cut, !stb,
                stb & c[bus_pin_oe_bit], stb & !c[bus_pin_oe_bit]};
    endfunction

    task automatic chk_units(input int s);
        chk(32'({tmr0, tmr1, shut_u, peri_u, voltage_detector_run,
                 por_low_power, bus_clk_keep, bus_pins_hold, bus_pins_hiz}),
            32'(exp_units(s)));
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // main sequence: reset, register map, every mode with a wake
    initial begin
        presetn = 1'b0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; wait_exec = 0; nmi_pin = 0; shutoff_cond = 0;
        external_pin_interrupts = 16'h0000; periph_wake = 8'h00;
        {ctrl_m, mon_m, stat_m, mask_m} = '0;
        void'($urandom(32'he52e));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk_units(0);
        foreach (base[i]) rd(8'(i * 4), 0);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'(err_q), 1);
        chk(rd_q, 0);
        wr(8'h14, 'h3ff);
        wr(state_off, 'h7);
        rd(ctrl_off, 0);
        rd(state_off, 0);
        for (int i = 0; i < 6; i++) begin
            wr(ctrl_off, base[i] | ($urandom & 'h3c8)
                         | (i == 3 ? 'h30 : ($urandom & 'h30)));
            wr(monitor_off, mons[i] | ($urandom & 'h3c));
            rd(ctrl_off, ctrl_m);
            rd(monitor_off, mon_m);
            chk(32'(mode_state), 0);
            if (!ctrl_m[standby_sel_bit])
                st = ctrl_m[clk_stop_en_bit] ? 2 : 1;
            else if (ctrl_m[deep_sel_bit] && (mon_m & 3) == 0)
                st = 4;
            else begin
                st = 3;
                if (ctrl_m[deep_sel_bit]) stat_m = stat_m | 2;
            end
            @(posedge pclk) wait_exec <= 1'b1;
            @(posedge pclk) wait_exec <= 1'b0;
            wait_state(3'(st));
            chk_units(st);
            rd(state_off, st);
            if (st == 2) begin
                wr(irq_mask_off, 7);
                @(posedge pclk) shutoff_cond <= 1'b1;
                @(posedge pclk) shutoff_cond <= 1'b0;
                repeat (4) @(posedge pclk);
                #1;
                chk(32'({mode_state, shutoff_irq, irq}), 32'h8);
                stat_m = stat_m | 4;
            end
            @(posedge pclk);
            case (i % 3)
                0: nmi_pin <= 1'b1;
                1: external_pin_interrupts <= 16'h1 << ($urandom % 16);
                default: periph_wake <= 8'h1 << ($urandom % 8);
            endcase
            if (st == 4) begin
                wait_state(3'd5);
                chk(32'(module_reset_n), 0);
            end
            wait_state(3'd0);
            stat_m = stat_m | 1;
            @(posedge pclk);
            {nmi_pin, external_pin_interrupts, periph_wake} <= '0;
            #1;
            chk_units(0);
            if (st == 2) chk(32'(shutoff_irq), 1);
            rd(irq_stat_off, stat_m);
            wr(irq_mask_off, $urandom & 7);
            #1;
            chk(32'(irq), 32'((stat_m & mask_m) != 0));
            wr(irq_stat_off, 7);
            #1;
            chk({irq, shutoff_irq}, 0);
            rd(irq_stat_off, 0);
        end
        // software stops monitor 2 step by step
        wr(monitor_off, 'h2c);
        #1;
        chk(32'(voltage_detector_run), 1);
        wr(monitor_off, mon_m & ~(1 << mon2_cmp_oe_bit));
        repeat (2 * 16 + 3) @(posedge pclk);
        wr(monitor_off, mon_m & ~(1 << mon2_irq_en_bit));
        wr(monitor_off, mon_m | (1 << mon2_filt_off_bit));
        wr(monitor_off, mon_m & ~(1 << det2_en_bit));
        #1;
        chk(32'(voltage_detector_run), 0);
        rd(monitor_off, mon_m);
        // reset in the middle of software standby
        wr(ctrl_off, 'h001);
        @(posedge pclk) wait_exec <= 1'b1;
        @(posedge pclk) wait_exec <= 1'b0;
        wait_state(3'd3);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {ctrl_m, mon_m, stat_m, mask_m} = '0;
        #1;
        chk(32'(mode_state), 0);
        chk_units(0);
        rd(ctrl_off, 0);
        rd(irq_stat_off, 0);
        end_of_test();
    end

endmodule

`default_nettype wire
